// ==== verilog/ppe_bank.sv ====
// apb slave holding the port h pull-up enables of the upper register
// assumes apb master on pclk; direction input comes from the port logic
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ppe_map.svh"

module ppe_bank (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire ppe_pkg::ppe_addr_type    paddr,
  input  wire ppe_pkg::ppe_word_type    pwdata,
  input  wire ppe_pkg::ppe_strb_type    pstrb,
  output var  logic                     pready,
  output var  ppe_pkg::ppe_word_type    prdata,
  output var  logic                     pslverr,
  input  wire ppe_pkg::ppe_pin_vec_type port_h_pins_is_input,
  output var  ppe_pkg::ppe_pin_vec_type port_h_pull_on
);

  // ***************************************************
  // bus decode
  // ***************************************************
  logic                     pready_q;
  logic                     pslverr_q;
  ppe_pkg::ppe_word_type    prdata_q;
  ppe_pkg::ppe_pin_vec_type ctrl_q;
  ppe_pkg::ppe_pin_vec_type pull_q;
  logic                     setup;
  logic                     hit;
  logic                     wr_take;

  // setup cycle: first cycle of a transfer
  assign setup = psel & ~penable;

  // RULE_01 word decode
  // compare word index only; bits 1:0 of paddr are ignored
  assign hit = paddr[`PPE_ADDR_MSB:`PPE_WORD_LSB] == `PPE_UPPER_IDX;

  // write lands only at the completing access edge
  assign wr_take = psel & penable & pready_q & pwrite & hit;

  // ***************************************************
  // handshake
  // ***************************************************
  // zero wait states: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  // RULE_01 unmapped error
  // any address other than the one word answers with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup & ~hit;
    end
  end

  // ***************************************************
  // control bits
  // ***************************************************
  // RULE_06 software write
  // only byte lane 3 carries port h; other lanes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PPE_H_RST;
    end else if (wr_take && pstrb[`PPE_H_LANE]) begin
      ctrl_q <= pwdata[`PPE_H_MSB:`PPE_H_LSB];
    end
  end

  // RULE_05 lower bits zero
  // read data is captured in setup so it is stable during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `PPE_WORD_ZERO;
    end else if (setup) begin
      if (hit && !pwrite) begin
        prdata_q <= {ctrl_q, `PPE_LOW_ZERO};
      end else begin
        prdata_q <= `PPE_WORD_ZERO;
      end
    end
  end

  // ***************************************************
  // pad pull-up drive
  // ***************************************************
  // RULE_02 pin order
  // bit n of ctrl_q is register bit 24+n and drives pin n
  for (genvar i = 0; i < `PPE_H_PINS; i++) begin : g_pin
    // RULE_03 RULE_04 gated pull
    // flop adds one cycle but keeps pad control glitch free
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pull_q[i] <= 1'b0;
      end else begin
        pull_q[i] <= ctrl_q[i] & port_h_pins_is_input[i];
      end
    end
  end

  // outputs come straight from the flops
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign prdata         = prdata_q;
  assign port_h_pull_on = pull_q;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // completed write of lane 3 to the mapped word
  sequence s_lane_write;
    psel && penable && pready && pwrite && hit && pstrb[`PPE_H_LANE];
  endsequence

  // completed read of the mapped word
  sequence s_word_read;
    psel && penable && pready && !pwrite && hit;
  endsequence

  // setup to an address that is not mapped
  sequence s_bad_setup;
    psel && !penable && !hit;
  endsequence

  // RULE_06 stored value
  a_write_stores: assert property ( // RULE_06
    s_lane_write |=> ctrl_q == $past(pwdata[`PPE_H_MSB:`PPE_H_LSB]))
    else $error("written port h bits not stored");

  // RULE_06 held without strobe
  a_strobe_masks: assert property ( // RULE_06
    psel && penable && pready && pwrite && !pstrb[`PPE_H_LANE]
    |=> $stable(ctrl_q))
    else $error("control changed without lane strobe");

  // RULE_05 read layout
  a_read_layout: assert property ( // RULE_05
    s_word_read |-> prdata[`PPE_H_MSB:`PPE_H_LSB] == ctrl_q &&
                    prdata[`PPE_LOW_MSB:0] == `PPE_LOW_ZERO)
    else $error("read data layout wrong");

  // RULE_01 error on miss
  a_miss_errors: assert property ( // RULE_01
    s_bad_setup |=> pready && pslverr)
    else $error("unmapped address not refused");

  // RULE_01 hit is clean
  a_hit_clean: assert property ( // RULE_01
    psel && !penable && hit |=> pready && !pslverr)
    else $error("mapped word answered with error");

  // ready for exactly one cycle
  a_ready_pulse: assert property ( // RULE_01
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  // RULE_03 follows control
  a_pull_follows: assert property ( // RULE_03
    1'b1 |=> port_h_pull_on ==
             $past(ctrl_q & port_h_pins_is_input))
    else $error("pull output does not follow control");

  // RULE_04 gated off
  a_pull_gated: assert property ( // RULE_04
    port_h_pins_is_input == 8'h00 |=> port_h_pull_on == 8'h00)
    else $error("pull on while pins not inputs");

  // RULE_02 top bit to pin 7
  a_bit_order: assert property ( // RULE_02
    s_lane_write ##0 pwdata[`PPE_H_MSB:`PPE_H_LSB] == 8'h80
    ##1 port_h_pins_is_input == 8'hFF |=> port_h_pull_on == 8'h80)
    else $error("register bit 31 not driving pin 7");

  // RULE_04 masked per pin
  a_pull_masked: assert property ( // RULE_04
    1'b1 |=> (port_h_pull_on & ~$past(port_h_pins_is_input)) == 8'h00)
    else $error("pull on for a pin that is not an input");

  // RULE_01 miss keeps bits
  a_miss_no_write: assert property ( // RULE_01
    psel && penable && pready && pwrite && !hit |=> $stable(ctrl_q))
    else $error("unmapped write changed control bits");

  // RULE_01 miss reads zero
  a_miss_rd_zero: assert property ( // RULE_01
    psel && penable && pready && !hit |-> prdata == `PPE_WORD_ZERO)
    else $error("unmapped access returned data");

  // RULE_01 ready after setup
  a_ready_origin: assert property ( // RULE_01
    pready |-> $past(psel && !penable))
    else $error("ready without a preceding setup cycle");

  // RULE_06 read data holds
  a_data_holds: assert property ( // RULE_06
    pready |=> $stable(prdata))
    else $error("read data moved right after access");

  // RULE_06 read is harmless
  a_read_keeps: assert property ( // RULE_06
    s_word_read |=> $stable(ctrl_q))
    else $error("read changed control bits");

  // all port h pins configured as inputs
  sequence s_pins_all_in;
    port_h_pins_is_input == 8'hFF;
  endsequence

  // RULE_03 written bits reach pads
  a_write_to_pad: assert property ( // RULE_03
    s_lane_write ##1 s_pins_all_in |=> port_h_pull_on == $past(ctrl_q))
    else $error("written bits did not reach the pads");

endmodule : ppe_bank

`default_nettype wire

// ==== verilog/ppe_map.svh ====
// offsets, field positions and reset values of the pull-up enable bank
// assumes inclusion by ppe_bank.sv only; holds definitions, no logic
//
// Contract
// RULE_01 - upper pull-up register decoded at byte 0xC
// RULE_02 - bits 31..24 map pins 7..0 of H
// RULE_03 - bit one enables pull-up, zero disables
// RULE_04 - pull-up off while pin is output/high-z
// RULE_05 - bits 23..0 belong to other ports
// RULE_06 - bits read back last write, reset zero
`ifndef PPE_MAP_SVH
`define PPE_MAP_SVH

// ***************************************************
// register map
// ***************************************************
`define PPE_UPPER_OFS    12'h00C
`define PPE_UPPER_IDX    10'h003
`define PPE_H_PINS       8
`define PPE_WORD_LSB     2
`define PPE_ADDR_MSB     11

// ***************************************************
// field layout and reset values
// ***************************************************
`define PPE_H_MSB        31
`define PPE_H_LSB        24
`define PPE_H_LANE       3
`define PPE_H_RST        8'h00
`define PPE_LOW_MSB      23
`define PPE_LOW_ZERO     24'h000000
`define PPE_WORD_ZERO    32'h00000000

`endif

// ==== verilog/ppe_pkg.sv ====
// types shared by the pull-up enable bank
// assumes nothing of its surroundings
`default_nettype none

package ppe_pkg;
  typedef logic [7:0]  ppe_pin_vec_type;
  typedef logic [31:0] ppe_word_type;
  typedef logic [11:0] ppe_addr_type;
  typedef logic [3:0]  ppe_strb_type;
endpackage : ppe_pkg

`default_nettype wire

// ==== test/tb_ppe_bank.sv ====
// self-checking bench for the port h pull-up enable bank
// assumes ppe_bank, ppe_pkg and ppe_map.svh are compiled before it
`timescale 1ns/1ps
`default_nettype none

module tb_ppe_bank;
  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic                     pready;
  logic                     pslverr;
  ppe_pkg::ppe_addr_type    paddr;
  ppe_pkg::ppe_word_type    pwdata;
  ppe_pkg::ppe_word_type    prdata;
  ppe_pkg::ppe_strb_type    pstrb;
  ppe_pkg::ppe_pin_vec_type pins_in;
  ppe_pkg::ppe_pin_vec_type pull_on;
  int                       n_mismatch = 0;
  int                       checked = 0;

  ppe_bank ppe_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port_h_pins_is_input(pins_in), .port_h_pull_on(pull_on));

  // ****************************************
  // clock and closing
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // runs far longer than the tests need, so only a hang reaches it
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk(input string nm, input ppe_pkg::ppe_word_type e,
                     input ppe_pkg::ppe_word_type g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; read data checked only on reads
  task automatic xfer(input logic w, input ppe_pkg::ppe_addr_type a,
                      input ppe_pkg::ppe_word_type d,
                      input ppe_pkg::ppe_strb_type s,
                      input ppe_pkg::ppe_word_type ed, input logic ee);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h00000001, {31'h00000000, pready});
    chk("pslverr", {31'h00000000, ee}, {31'h00000000, pslverr});
    if (!w) chk("prdata", ed, prdata);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // pad output lags its causes by one registered cycle
  task automatic pull(input ppe_pkg::ppe_pin_vec_type e);
    repeat (2) @(posedge pclk);
    chk("pull_on", {24'h000000, e}, {24'h000000, pull_on});
  endtask : pull

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
    pstrb   = 4'h0;
    pins_in = 8'hFF;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h00C, 32'h0, 4'h0, 32'h00000000, 1'b0);
    pull(8'h00);
    xfer(1'b1, 12'h00C, 32'hA5FFFFFF, 4'hF, 32'h0, 1'b0);
    xfer(1'b0, 12'h00C, 32'h0, 4'h0, 32'hA5000000, 1'b0);
    pull(8'hA5);
    pins_in <= 8'h0F;
    pull(8'h05);
    pins_in <= 8'h00;
    pull(8'h00);
    pins_in <= 8'hFF;
    // a write with byte lane three off must leave the bits alone
    xfer(1'b1, 12'h00C, 32'h00000000, 4'h7, 32'h0, 1'b0);
    xfer(1'b1, 12'h008, 32'hFF000000, 4'hF, 32'h0, 1'b1);
    xfer(1'b1, 12'h40C, 32'hFF000000, 4'hF, 32'h0, 1'b1);
    xfer(1'b0, 12'h010, 32'h0, 4'h0, 32'h00000000, 1'b1);
    xfer(1'b0, 12'h00C, 32'h0, 4'h0, 32'hA5000000, 1'b0);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 12'h00C, 32'h01000000 << i, 4'hF, 32'h0, 1'b0);
      pull(8'h01 << i);
    end
    // a second reset in mid-run must clear the stored bits
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pull(8'h00);
    xfer(1'b0, 12'h00C, 32'h0, 4'h0, 32'h00000000, 1'b0);
    conclude();
  end
endmodule : tb_ppe_bank

`default_nettype wire
